// ### rtl/tccp_pkg.sv
// constants shared by the timer capture/compare pair
package tccp_pkg;
    // register byte offsets
    localparam logic [7:0]  ADDR_FIRST         = 8'h00;
    localparam logic [7:0]  ADDR_SECOND        = 8'h04;
    localparam logic [7:0]  ADDR_COUNT         = 8'h08;
    localparam logic [7:0]  ADDR_CAPCMP        = 8'h0C;
    localparam logic [7:0]  ADDR_MODE          = 8'h10;
    localparam logic [7:0]  ADDR_PRESC         = 8'h14;
    localparam logic [7:0]  ADDR_OUTCTL        = 8'h18;
    // capcmp_control fields
    localparam int          CC_FIRST_MODE_BIT  = 0;
    localparam int          CC_TRIG_SRC_BIT    = 1;
    localparam int          CC_SECOND_MODE_BIT = 2;
    // timer_mode_control fields
    localparam int          TMC_OVF_BIT        = 0;
    localparam int          TMC_EDGE_REV_BIT   = 1;
    localparam int          TMC_MODE_LSB       = 2;
    // prescaler_mode fields
    localparam int          PRM_CLK_LSB        = 0;
    localparam int          PRM_PRI_LSB        = 4;
    localparam int          PRM_SEC_LSB        = 6;
    // output control fields
    localparam int          OUT_EN_BIT         = 0;
    localparam int          OUT_LVL_BIT        = 1;
    // reset values and counter wrap value
    localparam logic [15:0] CC_RST             = 16'h0000;
    localparam logic [15:0] COUNT_MAX          = 16'hFFFF;
    localparam logic [2:0]  CAPCMP_RST         = 3'h0;
    localparam logic [1:0]  MODE_FIELD_RST     = 2'h0;
    localparam logic [3:0]  EDGE_FIELDS_RST    = 4'h0;
    localparam logic [1:0]  CLK_SEL_RST        = 2'h0;
    // counting modes
    localparam logic [1:0]  MODE_STOP          = 2'h0;
    localparam logic [1:0]  MODE_FREE          = 2'h1;
    localparam logic [1:0]  MODE_CLR_EDGE      = 2'h2;
    localparam logic [1:0]  MODE_CLR_MATCH     = 2'h3;
    // edge codes
    localparam logic [1:0]  EDGE_FALL          = 2'h0;
    localparam logic [1:0]  EDGE_RISE          = 2'h1;
    localparam logic [1:0]  EDGE_BOTH          = 2'h3;
    // count clock selects and prescaler masks
    localparam logic [1:0]  CLK_DIRECT         = 2'h0;
    localparam logic [1:0]  CLK_DIV_FAST       = 2'h1;
    localparam logic [1:0]  CLK_DIV_SLOW       = 2'h2;
    localparam logic [1:0]  CLK_PRI_EDGE       = 2'h3;
    localparam logic [7:0]  DIV_FAST_MASK      = 8'h03;
    localparam logic [7:0]  DIV_SLOW_MASK      = 8'hFF;
endpackage : tccp_pkg

// ### rtl/tccp_top.sv
// timer counter with two capture/compare registers behind an apb slave
//
// What this block does
// R1 - capture source: primary pin if select set
// R2 - primary source captures opposite of valid edge
// R3 - secondary source captures on its coded edge
// R4 - software never writes edge code 10
// R5 - clear-on-match mode needs nonzero first register
// R6 - first zero: match at 0 to 1
// R7 - second zero: match at 0 to 1
// R8 - read/capture clash: stored capture stays correct
// R9 - shared pin: output or secondary input
// R10 - first register not rewritten while counting
// R11 - control bit 2 selects second capture
// R12 - second compares count, match raises irq
// R13 - second register resets to zero
// R14 - second captures on coded primary edge
// R15 - second capture ignores trigger source select
// R16 - first above zero, second any value
// R17 - pulse mode: second below first
// R18 - one-shot: two registers differ
// R19 - zero register: no match right after start
// R20 - opposite-phase capture: secondary edge interrupts only
// R21 - square/event modes: leave second unused
// R22 - first compare mode matches, ignores triggers
// R23 - counter steps on each count clock
// R24 - overflow flag set on wrap
// R25 - capture copies count in detect cycle
//
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module tccp_top (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // edge pins and shared output pin
    input  wire logic        primary_edge_input,
    input  wire logic        secondary_edge_input,
    output logic             timer_output_pin,
    output logic             timer_output_oe_n,
    // match events
    output logic             first_match_irq,
    output logic             second_match_irq
);
    ////////////////////////////////////////////////////////////////////////////
    logic [15:0] first_ff,   nxt_first;
    logic [15:0] second_ff,  nxt_second;
    logic [15:0] count_ff,   nxt_count;
    logic [2:0]  capcmp_ff,  nxt_capcmp;
    logic [1:0]  mode_ff,    nxt_mode;
    logic        rev_ff,     nxt_rev;
    logic        ovf_ff,     nxt_ovf;
    logic [3:0]  edges_ff,   nxt_edges;
    logic [1:0]  clksel_ff,  nxt_clksel;
    logic        oe_ff,      nxt_oe;
    logic        tout_ff,    nxt_tout;
    logic        armed_ff,   nxt_armed;
    logic [7:0]  presc_ff,   nxt_presc;
    logic        irq1_ff,    nxt_irq1;
    logic        irq2_ff,    nxt_irq2;
    logic [31:0] prdata_ff,  nxt_prdata;
    logic        pready_ff,  nxt_pready;
    logic        pslverr_ff, nxt_pslverr;
    logic [1:0]  sync1_ff;
    logic [1:0]  sync2_ff;
    logic [1:0]  sync3_ff;

    logic        wr_en;
    logic        running;
    logic        tick;
    logic        pri_rise, pri_fall, sec_rise, sec_fall;
    logic        pri_valid, pri_opp, sec_valid;
    logic        clr_edge, clr_match, wrap, step01;
    logic        hit1, hit2, cap1, cap2;
    logic [15:0] incr;
    logic [1:0]  pri_code, sec_code;

    function automatic logic edge_hit(input logic [1:0] code, input logic rise,
                                      input logic fall);
        case (code)
            tccp_pkg::EDGE_FALL: edge_hit = fall;
            tccp_pkg::EDGE_RISE: edge_hit = rise;
            tccp_pkg::EDGE_BOTH: edge_hit = rise | fall;
            default:             edge_hit = 1'b0;
        endcase
    endfunction : edge_hit

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers; bit 0 primary, bit 1 secondary
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sync1_ff <= 2'h0;
            sync2_ff <= 2'h0;
            sync3_ff <= 2'h0;
        end else begin
            sync1_ff <= {secondary_edge_input, primary_edge_input};
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // event decode
    always_comb begin
        pri_code  = edges_ff[1:0];
        sec_code  = edges_ff[3:2];
        pri_rise  = sync2_ff[0] & ~sync3_ff[0];
        pri_fall  = ~sync2_ff[0] & sync3_ff[0];
        sec_rise  = sync2_ff[1] & ~sync3_ff[1];
        sec_fall  = ~sync2_ff[1] & sync3_ff[1];
        pri_valid = edge_hit(pri_code, pri_rise, pri_fall);
        pri_opp   = edge_hit(pri_code, pri_fall, pri_rise) & (pri_code != tccp_pkg::EDGE_BOTH); // R2
        sec_valid = ~oe_ff & edge_hit(sec_code, sec_rise, sec_fall); // R9
        running   = mode_ff != tccp_pkg::MODE_STOP;
        case (clksel_ff)
            tccp_pkg::CLK_DIRECT:   tick = running;
            tccp_pkg::CLK_DIV_FAST: tick = running & ((presc_ff & tccp_pkg::DIV_FAST_MASK) == tccp_pkg::DIV_FAST_MASK);
            tccp_pkg::CLK_DIV_SLOW: tick = running & (presc_ff == tccp_pkg::DIV_SLOW_MASK);
            default:                tick = running & pri_valid;
        endcase
        incr      = 16'(count_ff + 16'h0001);
        clr_edge  = (mode_ff == tccp_pkg::MODE_CLR_EDGE) & pri_valid;
        clr_match = (mode_ff == tccp_pkg::MODE_CLR_MATCH) & tick & (count_ff == first_ff);
        wrap      = tick & ~clr_edge & ~clr_match & (count_ff == tccp_pkg::COUNT_MAX);
        step01    = tick & ~clr_edge & ~clr_match & armed_ff & (count_ff == 16'h0000); // R19
        hit1      = running & ~capcmp_ff[tccp_pkg::CC_FIRST_MODE_BIT] &
                    ((first_ff == 16'h0000) ? step01 : (tick & ~clr_edge & ~clr_match & (incr == first_ff))); // R6 R22
        hit2      = running & ~capcmp_ff[tccp_pkg::CC_SECOND_MODE_BIT] &
                    ((second_ff == 16'h0000) ? step01 : (tick & ~clr_edge & ~clr_match & (incr == second_ff))); // R7 R12
        cap1      = capcmp_ff[tccp_pkg::CC_FIRST_MODE_BIT] &
                    (capcmp_ff[tccp_pkg::CC_TRIG_SRC_BIT] ? pri_opp : sec_valid); // R1 R3
        cap2      = capcmp_ff[tccp_pkg::CC_SECOND_MODE_BIT] & pri_valid; // R11 R14 R15
    end

    ////////////////////////////////////////////////////////////////////////////
    // counter, captures, registers
    always_comb begin
        wr_en      = psel & penable & pready_ff & pwrite;
        nxt_presc  = running ? 8'(presc_ff + 8'h01) : 8'h00;
        nxt_count  = count_ff;
        if (!running || clr_edge || clr_match)
            nxt_count = 16'h0000;
        else if (tick)
            nxt_count = incr; // R23
        nxt_armed  = running & (armed_ff | clr_edge | clr_match | wrap);
        nxt_first  = first_ff;
        nxt_second = second_ff;
        nxt_capcmp = capcmp_ff;
        nxt_mode   = mode_ff;
        nxt_rev    = rev_ff;
        nxt_ovf    = running ? ovf_ff : 1'b0;
        nxt_edges  = edges_ff;
        nxt_clksel = clksel_ff;
        nxt_oe     = oe_ff;
        if (wr_en) begin
            case (paddr)
                tccp_pkg::ADDR_FIRST:  nxt_first  = pwdata[15:0];
                tccp_pkg::ADDR_SECOND: nxt_second = pwdata[15:0];
                tccp_pkg::ADDR_CAPCMP: nxt_capcmp = pwdata[2:0];
                tccp_pkg::ADDR_MODE: begin
                    nxt_mode = pwdata[tccp_pkg::TMC_MODE_LSB +: 2];
                    nxt_rev  = pwdata[tccp_pkg::TMC_EDGE_REV_BIT];
                    nxt_ovf  = pwdata[tccp_pkg::TMC_OVF_BIT];
                end
                tccp_pkg::ADDR_PRESC: begin
                    nxt_clksel = pwdata[tccp_pkg::PRM_CLK_LSB +: 2];
                    nxt_edges  = {pwdata[tccp_pkg::PRM_SEC_LSB +: 2], pwdata[tccp_pkg::PRM_PRI_LSB +: 2]};
                end
                tccp_pkg::ADDR_OUTCTL: nxt_oe = pwdata[tccp_pkg::OUT_EN_BIT];
                default: ;
            endcase
        end
        // hardware events win over a software write in the same cycle
        if (wrap)
            nxt_ovf = 1'b1; // R24
        if (cap1)
            nxt_first = count_ff; // R25 R8
        if (cap2)
            nxt_second = count_ff; // R25
        nxt_irq1 = hit1 | (cap1 & ~capcmp_ff[tccp_pkg::CC_TRIG_SRC_BIT]) |
                   (capcmp_ff[tccp_pkg::CC_FIRST_MODE_BIT] & capcmp_ff[tccp_pkg::CC_TRIG_SRC_BIT] & sec_valid); // R20
        nxt_irq2 = hit2 | cap2;
        nxt_tout = tout_ff ^ (hit1 | hit2 | (rev_ff & running & pri_valid));
    end

    ////////////////////////////////////////////////////////////////////////////
    // apb answer: access phase always one cycle
    always_comb begin
        nxt_pready  = psel & ~penable;
        nxt_pslverr = 1'b0;
        nxt_prdata  = 32'h0000_0000;
        if (psel && !penable) begin
            case (paddr)
                tccp_pkg::ADDR_FIRST:  nxt_prdata[15:0] = first_ff;
                tccp_pkg::ADDR_SECOND: nxt_prdata[15:0] = second_ff;
                tccp_pkg::ADDR_COUNT:  nxt_prdata[15:0] = count_ff;
                tccp_pkg::ADDR_CAPCMP: nxt_prdata[2:0]  = capcmp_ff;
                tccp_pkg::ADDR_MODE:   nxt_prdata[3:0]  = {mode_ff, rev_ff, ovf_ff};
                tccp_pkg::ADDR_PRESC:  nxt_prdata[7:0]  = {edges_ff[3:2], edges_ff[1:0], 2'h0, clksel_ff};
                tccp_pkg::ADDR_OUTCTL: nxt_prdata[1:0]  = {tout_ff, oe_ff};
                default:               nxt_pslverr      = 1'b1;
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            first_ff   <= tccp_pkg::CC_RST;
            second_ff  <= tccp_pkg::CC_RST; // R13
            count_ff   <= tccp_pkg::CC_RST;
            capcmp_ff  <= tccp_pkg::CAPCMP_RST;
            mode_ff    <= tccp_pkg::MODE_FIELD_RST;
            rev_ff     <= 1'b0;
            ovf_ff     <= 1'b0;
            edges_ff   <= tccp_pkg::EDGE_FIELDS_RST;
            clksel_ff  <= tccp_pkg::CLK_SEL_RST;
            oe_ff      <= 1'b0;
            tout_ff    <= 1'b0;
            armed_ff   <= 1'b0;
            presc_ff   <= 8'h00;
            irq1_ff    <= 1'b0;
            irq2_ff    <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            first_ff   <= nxt_first;
            second_ff  <= nxt_second;
            count_ff   <= nxt_count;
            capcmp_ff  <= nxt_capcmp;
            mode_ff    <= nxt_mode;
            rev_ff     <= nxt_rev;
            ovf_ff     <= nxt_ovf;
            edges_ff   <= nxt_edges;
            clksel_ff  <= nxt_clksel;
            oe_ff      <= nxt_oe;
            tout_ff    <= nxt_tout;
            armed_ff   <= nxt_armed;
            presc_ff   <= nxt_presc;
            irq1_ff    <= nxt_irq1;
            irq2_ff    <= nxt_irq2;
            prdata_ff  <= nxt_prdata;
            pready_ff  <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
        end
    end

    assign prdata            = prdata_ff;
    assign pready            = pready_ff;
    assign pslverr           = pslverr_ff;
    assign timer_output_pin  = tout_ff;
    assign timer_output_oe_n = ~oe_ff;
    assign first_match_irq   = irq1_ff;
    assign second_match_irq  = irq2_ff;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence s_first_cap_pri;
        capcmp_ff[0] && capcmp_ff[1] && pri_opp;
    endsequence
    sequence s_first_cap_sec;
        capcmp_ff[0] && !capcmp_ff[1] && sec_valid;
    endsequence
    sequence s_zero_step;
        running && tick && armed_ff && count_ff == 16'h0000 && !clr_edge && !clr_match;
    endsequence

    AST_PRI_CAPTURE: assert property (s_first_cap_pri |=> // R2
        first_ff == $past(count_ff) && first_match_irq == $past(sec_valid))
        else $error("primary capture into first register wrong");
    AST_SEC_CAPTURE: assert property (s_first_cap_sec |=> first_ff == $past(count_ff) && first_match_irq) // R3
        else $error("secondary capture into first register wrong");
    AST_FIRST_ZERO: assert property (s_zero_step ##0 (first_ff == 16'h0000 && !capcmp_ff[0]) |=> first_match_irq) // R6
        else $error("first zero match missing at count 0 to 1");
    AST_SECOND_ZERO: assert property (s_zero_step ##0 (second_ff == 16'h0000 && !capcmp_ff[2]) |=> second_match_irq) // R7
        else $error("second zero match missing at count 0 to 1");
    AST_NO_EARLY: assert property ($rose(running) && second_ff == 16'h0000 && !capcmp_ff[2] |=> !second_match_irq [*2]) // R19
        else $error("zero compare fired just after start");
    AST_EXT_IRQ: assert property (capcmp_ff[0] && capcmp_ff[1] && sec_valid && !pri_opp && !wr_en |=> first_match_irq && $stable(first_ff)) // R20
        else $error("secondary edge must interrupt without capture");
    AST_SECOND_CAP: assert property (capcmp_ff[2] && pri_valid |=> second_ff == $past(count_ff) && second_match_irq) // R14
        else $error("second register capture wrong");
    AST_SECOND_CMP: assert property (!capcmp_ff[2] && running && tick && !clr_edge && !clr_match && second_ff != 16'h0000 && incr == second_ff |=> second_match_irq) // R12
        else $error("second compare match missed");
    AST_NO_FIRST_CAP: assert property (!capcmp_ff[0] && !wr_en |=> $stable(first_ff)) // R22
        else $error("first register changed in compare mode");
    AST_COUNT_STEP: assert property (tick && !clr_edge && !clr_match |=> count_ff == 16'($past(count_ff) + 16'h0001)) // R23
        else $error("counter did not step on count clock");
    AST_OVERFLOW: assert property (wrap |=> ovf_ff && count_ff == 16'h0000) // R24
        else $error("overflow flag not set on wrap");
    AST_PIN_SHARE: assert property (oe_ff && capcmp_ff[0] && !capcmp_ff[1] && !wr_en |=> $stable(first_ff)) // R9
        else $error("secondary input used while pin drives output");
endmodule : tccp_top
`default_nettype wire

// ### test/tccp_pin_model.sv
// far-side model: external sources driving the two timer edge pins
`timescale 1ns/100ps
`default_nettype none
module tccp_pin_model (
    // clock
    input  wire logic clk,
    // pin drives
    output logic      pri_pin,
    output logic      sec_pin
);
    initial begin
        pri_pin = 1'b0;
        sec_pin = 1'b0;
    end
    // one high pulse, edges far wider apart than the two-clock minimum
    task automatic pulse(input logic sel, input int gap);
        @(posedge clk);
        if (sel) begin
            sec_pin <= 1'b1;
        end else begin
            pri_pin <= 1'b1;
        end
        repeat (gap) @(posedge clk);
        if (sel) begin
            sec_pin <= 1'b0;
        end else begin
            pri_pin <= 1'b0;
        end
        // let synchroniser and capture settle
        repeat (8) @(posedge clk);
    endtask : pulse
endmodule : tccp_pin_model
`default_nettype wire

// ### test/testbench.sv
// self-checking bench for the timer capture/compare pair
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic        clk;
    logic        nrst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        pri_pin;
    logic        sec_drv;
    logic        sec_wire;
    logic        tout;
    logic        tout_oe_n;
    logic        irq1;
    logic        irq2;
    logic [31:0] q;
    logic [31:0] a;
    logic        err;
    int          errors;
    int          num_checks;
    int          cyc, n1, n2, t1p, t1l, t2p, t2l, k1, k2;
    logic [1:0]  cd [3] = '{tccp_pkg::EDGE_FALL, tccp_pkg::EDGE_RISE, tccp_pkg::EDGE_BOTH};
    int          ex [3] = '{1, 1, 2};

    // shared pin: block output wins while its enable is active
    assign sec_wire = tout_oe_n ? sec_drv : tout;

    tccp_top dut_u (
        .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .primary_edge_input(pri_pin),
        .secondary_edge_input(sec_wire), .timer_output_pin(tout),
        .timer_output_oe_n(tout_oe_n), .first_match_irq(irq1), .second_match_irq(irq2)
    );
    tccp_pin_model pm_u (.clk(clk), .pri_pin(pri_pin), .sec_pin(sec_drv));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // event counters and times of the last two pulses
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (irq1 === 1'b1) begin
            n1  <= n1 + 1;
            t1p <= t1l;
            t1l <= cyc;
        end
        if (irq2 === 1'b1) begin
            n2  <= n2 + 1;
            t2p <= t2l;
            t2l <= cyc;
        end
    end

    task automatic close_out();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : close_out

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
        // idle edge: psel is never released and raised in one step
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= ad;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (int i = 0; i < 20; i++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
            if (i == 19) begin
                errors++;
                close_out();
            end
        end
        q = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        apb(1'b1, ad, d);
    endtask : wr

    task automatic rd(input logic [7:0] ad);
        apb(1'b0, ad, 32'h0);
    endtask : rd

    task automatic set_mode(input logic [1:0] m);
        wr(tccp_pkg::ADDR_MODE, {28'h0000000, m, 2'b00});
    endtask : set_mode

    task automatic pre(input logic [1:0] s, input logic [1:0] p);
        wr(tccp_pkg::ADDR_PRESC, {24'h000000, s, p, 4'h0});
    endtask : pre

    task automatic wait_irq(input logic sel, input int tgt, input int bound);
        for (int i = 0; i < bound; i++) begin
            @(posedge clk);
            if ((sel ? n2 : n1) >= tgt) return;
        end
        errors++;
        close_out();
    endtask : wait_irq

    initial begin
        repeat (100000) @(posedge clk);
        errors++;
        close_out();
    end

    initial begin
        nrst = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        ////////////////////////////////////////////////////////////////
        rd(tccp_pkg::ADDR_SECOND);
        chk("second reset", 32'h0, q);
        rd(8'h1C);
        chk("unmapped error", 32'h1, {31'h0, err});
        ////////////////////////////////////////////////////////////////
        // one primary pulse captures into both registers
        wr(tccp_pkg::ADDR_CAPCMP, 32'h7);
        pre(tccp_pkg::EDGE_FALL, tccp_pkg::EDGE_RISE);
        set_mode(tccp_pkg::MODE_FREE);
        k1 = n1;
        k2 = n2;
        pm_u.pulse(1'b0, 30);
        rd(tccp_pkg::ADDR_SECOND);
        a = q;
        rd(tccp_pkg::ADDR_FIRST);
        chk("capture spacing", 32'h1E, q - a);
        chk("first irq count", 32'(k1), 32'(n1));
        chk("second irq count", 32'(k2 + 1), 32'(n2));
        ////////////////////////////////////////////////////////////////
        wr(tccp_pkg::ADDR_CAPCMP, 32'h5);
        for (int i = 0; i < 3; i++) begin
            pre(cd[i], cd[i]);
            k1 = n1;
            k2 = n2;
            pm_u.pulse(1'b0, 30);
            pm_u.pulse(1'b1, 30);
            chk("second captures", 32'(k2 + ex[i]), 32'(n2));
            chk("first captures", 32'(k1 + ex[i]), 32'(n1));
        end
        ////////////////////////////////////////////////////////////////
        // opposite-phase capture: secondary edge only interrupts
        wr(tccp_pkg::ADDR_CAPCMP, 32'h3);
        pre(tccp_pkg::EDGE_RISE, tccp_pkg::EDGE_RISE);
        rd(tccp_pkg::ADDR_FIRST);
        a = q;
        k1 = n1;
        pm_u.pulse(1'b1, 30);
        rd(tccp_pkg::ADDR_FIRST);
        chk("first held", a, q);
        chk("external irq", 32'(k1 + 1), 32'(n1));
        ////////////////////////////////////////////////////////////////
        set_mode(tccp_pkg::MODE_STOP);
        wr(tccp_pkg::ADDR_CAPCMP, 32'h0);
        wr(tccp_pkg::ADDR_FIRST, 32'hFFFF);
        wr(tccp_pkg::ADDR_SECOND, 32'hC8);
        set_mode(tccp_pkg::MODE_FREE);
        k2 = n2;
        wait_irq(1'b1, k2 + 1, 400);
        wr(tccp_pkg::ADDR_SECOND, 32'h12C);
        wait_irq(1'b1, k2 + 2, 400);
        chk("second match spacing", 32'h64, 32'(t2l - t2p));
        ////////////////////////////////////////////////////////////////
        set_mode(tccp_pkg::MODE_STOP);
        wr(tccp_pkg::ADDR_FIRST, 32'h32);
        set_mode(tccp_pkg::MODE_CLR_MATCH);
        k1 = n1;
        wait_irq(1'b0, k1 + 2, 200);
        chk("first match period", 32'h33, 32'(t1l - t1p));
        pm_u.pulse(1'b0, 30);
        rd(tccp_pkg::ADDR_FIRST);
        chk("first ignores trigger", 32'h32, q);
        ////////////////////////////////////////////////////////////////
        // zero compare values fire only after the wrap
        set_mode(tccp_pkg::MODE_STOP);
        wr(tccp_pkg::ADDR_FIRST, 32'h0);
        wr(tccp_pkg::ADDR_SECOND, 32'h0);
        set_mode(tccp_pkg::MODE_FREE);
        k1 = n1;
        k2 = n2;
        repeat (100) @(posedge clk);
        chk("no early irq", 32'(k2), 32'(n2));
        wait_irq(1'b1, k2 + 1, 70000);
        chk("first irq at wrap", 32'(k1 + 1), 32'(n1));
        chk("irqs together", 32'(t1l), 32'(t2l));
        rd(tccp_pkg::ADDR_MODE);
        chk("overflow flag", 32'h5, q);
        ////////////////////////////////////////////////////////////////
        // pin as output: outside and own edges on it are ignored
        set_mode(tccp_pkg::MODE_STOP);
        wr(tccp_pkg::ADDR_CAPCMP, 32'h1);
        wr(tccp_pkg::ADDR_OUTCTL, 32'h1);
        wr(tccp_pkg::ADDR_MODE, 32'h6);
        k1 = n1;
        a = {31'h0, tout};
        pm_u.pulse(1'b1, 30);
        pm_u.pulse(1'b0, 30);
        chk("pin enable", 32'h0, {31'h0, tout_oe_n});
        chk("output toggle", a ^ 32'h1, {31'h0, tout});
        chk("secondary blocked", 32'(k1), 32'(n1));
        close_out();
    end
endmodule : testbench
`default_nettype wire
